// *** hw/mmd_mul_unit.sv ***
// multiply and multiply-accumulate execution unit, low 32-bit result
`timescale 1ns/1ps
`default_nettype none
module mmd_mul_unit
  import mmd_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  // instruction issue
  input  wire logic                 instr_valid,
  input  wire logic [DATA_W-1:0]    instr_word,
  input  wire logic [FLAG_W-1:0]    status_flags,
  output logic                      busy,
  output logic                      not_multiply,
  // register file read
  output logic      [REG_IDX_W-1:0] rd_addr_a,
  output logic      [REG_IDX_W-1:0] rd_addr_b,
  output logic      [REG_IDX_W-1:0] rd_addr_c,
  input  wire logic [DATA_W-1:0]    rd_data_a,
  input  wire logic [DATA_W-1:0]    rd_data_b,
  input  wire logic [DATA_W-1:0]    rd_data_c,
  // register file write
  output logic                      wr_en,
  output logic      [REG_IDX_W-1:0] wr_addr,
  output logic      [DATA_W-1:0]    wr_data,
  // flag update
  output logic                      flags_we,
  output logic      [FLAG_W-1:0]    flags_out,
  // completion
  output logic                      done
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic cond_pass(input logic [3:0] cc,
                                     input logic [3:0] f);
    logic n;
    logic z;
    logic c;
    logic v;
    n = f[FLAG_N];
    z = f[FLAG_Z];
    c = f[FLAG_C];
    v = f[FLAG_V];
    case (cc)
      CC_EQ: cond_pass = z;
      CC_NE: cond_pass = !z;
      CC_CS: cond_pass = c;
      CC_CC: cond_pass = !c;
      CC_MI: cond_pass = n;
      CC_PL: cond_pass = !n;
      CC_VS: cond_pass = v;
      CC_VC: cond_pass = !v;
      CC_HI: cond_pass = c && !z;
      CC_LS: cond_pass = !c || z;
      CC_GE: cond_pass = n == v;
      CC_LT: cond_pass = n != v;
      CC_GT: cond_pass = !z && (n == v);
      CC_LE: cond_pass = z || (n != v);
      CC_AL: cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  endfunction

  // array cycle count from the multiplier operand
  function automatic logic [CYC_W-1:0] step_count(input logic [31:0] m);
    if (m[31:8] == 24'h000000 || m[31:8] == 24'hffffff)
      step_count = 3'h1;
    else if (m[31:16] == 16'h0000 || m[31:16] == 16'hffff)
      step_count = 3'h2;
    else if (m[31:24] == 8'h00 || m[31:24] == 8'hff)
      step_count = 3'h3;
    else
      step_count = MAX_STEPS;
  endfunction

  // ****************************************
  // decode
  // ****************************************
  logic is_mul;
  logic go;

  assign is_mul = (instr_word[CLASS_HI:CLASS_LO] == CLASS_VAL)
               && (instr_word[SIG_HI:SIG_LO] == SIG_VAL);
  assign go = instr_valid && is_mul
           && cond_pass(instr_word[COND_HI:COND_LO], status_flags);

  mmd_state_e          state_q;
  mmd_state_e          state_d;
  logic                acc_op_q;
  logic                setf_q;
  logic [REG_IDX_W-1:0] dest_q;
  logic [3:0]          flags_in_q;
  logic [DATA_W-1:0]   acc_q;
  logic [DATA_W-1:0]   mcand_q;
  logic [DATA_W-1:0]   mult_q;
  logic [DATA_W-1:0]   addend_q;
  logic                carry_q;
  logic                sign_q;
  logic [CYC_W-1:0]    steps_q;
  logic [CYC_W-1:0]    cnt_q;

  // ****************************************
  // instruction capture
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      acc_op_q   <= 1'b0;
      setf_q     <= 1'b0;
      dest_q     <= '0;
      flags_in_q <= '0;
      rd_addr_a  <= '0;
      rd_addr_b  <= '0;
      rd_addr_c  <= '0;
    end
    else if (state_q == MMD_IDLE && go)
    begin
      acc_op_q   <= instr_word[ACC_BIT];
      setf_q     <= instr_word[SETF_BIT];
      dest_q     <= instr_word[RD_HI:RD_LO];
      rd_addr_a  <= instr_word[RM_HI:RM_LO];
      rd_addr_b  <= instr_word[RS_HI:RS_LO];
      rd_addr_c  <= instr_word[RN_HI:RN_LO];
      flags_in_q <= status_flags;
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      MMD_IDLE: if (go) state_d = MMD_READ;
      MMD_READ: state_d = MMD_MULT;
      // m internal cycles, one more when accumulating
      MMD_MULT: if (cnt_q == steps_q)
                  state_d = acc_op_q ? MMD_ACCU : MMD_DONE;
      MMD_ACCU: state_d = MMD_DONE;
      MMD_DONE: state_d = MMD_IDLE;
      default:  state_d = MMD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state_q <= MMD_IDLE;
    else
      state_q <= state_d;
  end

  // ****************************************
  // booth datapath
  // ****************************************
  logic [DATA_W-1:0] acc_nx;
  logic [DATA_W-1:0] mcand_nx;
  logic              carry_nx;

  mmd_booth_step u_step
  (
    .acc_in    (acc_q),
    .mcand_in  (mcand_q),
    .mult_byte (mult_q[STEP_BITS-1:0]),
    .carry_in  (carry_q),
    .acc_out   (acc_nx),
    .mcand_out (mcand_nx),
    .carry_out (carry_nx)
  );

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      acc_q    <= '0;
      mcand_q  <= '0;
      mult_q   <= '0;
      addend_q <= '0;
      carry_q  <= 1'b0;
      sign_q   <= 1'b0;
      steps_q  <= '0;
      cnt_q    <= '0;
    end
    else if (state_q == MMD_READ)
    begin
      // all operands latched together before any write
      acc_q    <= '0;
      mcand_q  <= rd_data_a;
      mult_q   <= rd_data_b;
      // accumulate operand ignored for plain multiply
      addend_q <= acc_op_q ? rd_data_c : '0;
      carry_q  <= 1'b0;
      steps_q  <= step_count(rd_data_b);
      // sign of the bits that early termination never visits
      sign_q   <= rd_data_b[DATA_W-1];
      cnt_q    <= 3'h1;
    end
    else if (state_q == MMD_MULT)
    begin
      // last step settles recode carry against upper sign
      if (cnt_q == steps_q && carry_nx && !sign_q)
        acc_q <= acc_nx + mcand_nx;
      else if (cnt_q == steps_q && !carry_nx && sign_q)
        acc_q <= acc_nx - mcand_nx;
      else
        acc_q <= acc_nx;
      mcand_q <= mcand_nx;
      mult_q  <= mult_q >> STEP_BITS;
      carry_q <= carry_nx;
      cnt_q   <= cnt_q + 3'h1;
    end
    else if (state_q == MMD_ACCU)
      acc_q <= acc_q + addend_q;
  end

  // ****************************************
  // writeback
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wr_en     <= 1'b0;
      wr_addr   <= '0;
      wr_data   <= '0;
      flags_we  <= 1'b0;
      flags_out <= '0;
      done      <= 1'b0;
    end
    else
    begin
      wr_en    <= 1'b0;
      flags_we <= 1'b0;
      done     <= 1'b0;
      if (state_q == MMD_DONE)
      begin
        wr_en   <= 1'b1;
        wr_addr <= dest_q;
        wr_data <= acc_q;
        done    <= 1'b1;
        if (setf_q)
        begin
          flags_we <= 1'b1;
          flags_out[FLAG_N] <= acc_q[DATA_W-1];
          flags_out[FLAG_Z] <= (acc_q == '0);
          flags_out[FLAG_C] <= flags_in_q[FLAG_C];
          flags_out[FLAG_V] <= flags_in_q[FLAG_V];
        end
      end
    end
  end

  // ****************************************
  // status
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      busy         <= 1'b0;
      not_multiply <= 1'b0;
    end
    else
    begin
      busy         <= (state_d != MMD_IDLE);
      not_multiply <= (state_q == MMD_IDLE) && instr_valid && !is_mul;
    end
  end
endmodule
`default_nettype wire

// *** include/mmd_pkg.sv ***
// constants shared by the multiply and multiply-accumulate datapath
package mmd_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned REG_IDX_W   = 4;
  localparam int unsigned FLAG_W      = 4;
  localparam int unsigned CYC_W       = 3;
  // instruction fields
  localparam int unsigned COND_HI     = 31;
  localparam int unsigned COND_LO     = 28;
  localparam int unsigned CLASS_HI    = 27;
  localparam int unsigned CLASS_LO    = 22;
  localparam int unsigned ACC_BIT     = 21;
  localparam int unsigned SETF_BIT    = 20;
  localparam int unsigned RD_HI       = 19;
  localparam int unsigned RD_LO       = 16;
  localparam int unsigned RN_HI       = 15;
  localparam int unsigned RN_LO       = 12;
  localparam int unsigned RS_HI       = 11;
  localparam int unsigned RS_LO       = 8;
  localparam int unsigned SIG_HI      = 7;
  localparam int unsigned SIG_LO      = 4;
  localparam int unsigned RM_HI       = 3;
  localparam int unsigned RM_LO       = 0;
  localparam logic [5:0]  CLASS_VAL   = 6'h00;
  localparam logic [3:0]  SIG_VAL     = 4'h9;
  // flag positions in the nibble n z c v
  localparam int unsigned FLAG_N      = 3;
  localparam int unsigned FLAG_Z      = 2;
  localparam int unsigned FLAG_C      = 1;
  localparam int unsigned FLAG_V      = 0;
  // booth array step width and maximum step count
  localparam int unsigned STEP_BITS   = 8;
  localparam logic [2:0]  MAX_STEPS   = 3'h4;
  // condition codes
  localparam logic [3:0]  CC_EQ = 4'h0;
  localparam logic [3:0]  CC_NE = 4'h1;
  localparam logic [3:0]  CC_CS = 4'h2;
  localparam logic [3:0]  CC_CC = 4'h3;
  localparam logic [3:0]  CC_MI = 4'h4;
  localparam logic [3:0]  CC_PL = 4'h5;
  localparam logic [3:0]  CC_VS = 4'h6;
  localparam logic [3:0]  CC_VC = 4'h7;
  localparam logic [3:0]  CC_HI = 4'h8;
  localparam logic [3:0]  CC_LS = 4'h9;
  localparam logic [3:0]  CC_GE = 4'ha;
  localparam logic [3:0]  CC_LT = 4'hb;
  localparam logic [3:0]  CC_GT = 4'hc;
  localparam logic [3:0]  CC_LE = 4'hd;
  localparam logic [3:0]  CC_AL = 4'he;
  // control states
  typedef enum logic [4:0]
  {
    MMD_IDLE = 5'h01,
    MMD_READ = 5'h02,
    MMD_MULT = 5'h04,
    MMD_ACCU = 5'h08,
    MMD_DONE = 5'h10
  } mmd_state_e;
endpackage

// *** hw/mmd_booth_step.sv ***
// one radix-256 booth array step: retires 8 multiplier bits
`timescale 1ns/1ps
`default_nettype none
module mmd_booth_step
  import mmd_pkg::*;
(
  // partial state in
  input  wire logic [DATA_W-1:0]    acc_in,
  input  wire logic [DATA_W-1:0]    mcand_in,
  input  wire logic [STEP_BITS-1:0] mult_byte,
  input  wire logic                 carry_in,
  // partial state out
  output logic      [DATA_W-1:0]    acc_out,
  output logic      [DATA_W-1:0]    mcand_out,
  output logic                      carry_out
);
  logic [8:0]        digit;
  logic [DATA_W-1:0] term;

  // booth digit = byte + incoming carry, recoded to signed range
  always_comb
  begin
    digit = {1'b0, mult_byte} + {8'h00, carry_in};
    if (digit[7] || digit[8])
    begin
      carry_out = 1'b1;
      term      = mcand_in * {23'h000000, digit} - (mcand_in << 8);
    end
    else
    begin
      carry_out = 1'b0;
      term      = mcand_in * {23'h000000, digit};
    end
    acc_out   = acc_in + term;
    mcand_out = mcand_in << 8;
  end
endmodule
`default_nettype wire

// *** sim/mmd_mul_monitor.sv ***
// port checker for the multiply datapath
`timescale 1ns/1ps
`default_nettype none
module mmd_mul_monitor
  import mmd_pkg::*;
(
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 srst,
  // issue
  input wire logic                 instr_valid,
  input wire logic [DATA_W-1:0]    instr_word,
  input wire logic [FLAG_W-1:0]    status_flags,
  input wire logic                 busy,
  input wire logic                 not_multiply,
  // register file
  input wire logic [REG_IDX_W-1:0] rd_addr_a,
  input wire logic [REG_IDX_W-1:0] rd_addr_b,
  input wire logic [REG_IDX_W-1:0] rd_addr_c,
  input wire logic [DATA_W-1:0]    rd_data_a,
  input wire logic [DATA_W-1:0]    rd_data_b,
  input wire logic [DATA_W-1:0]    rd_data_c,
  input wire logic                 wr_en,
  input wire logic [REG_IDX_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0]    wr_data,
  // flags and completion
  input wire logic                 flags_we,
  input wire logic [FLAG_W-1:0]    flags_out,
  input wire logic                 done
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  a_done_write:
    assert property (done |-> wr_en && !busy) else $error("done w/o write");
  a_flag_pair:
    assert property (flags_we |-> wr_en) else $error("flag write alone");
  a_neg_flag:
    assert property (flags_we |-> flags_out[FLAG_N] == wr_data[31])
      else $error("negative flag wrong");
  a_zero_flag:
    assert property (flags_we |-> flags_out[FLAG_Z] == (wr_data == '0))
      else $error("zero flag wrong");
  a_ovf_kept:
    assert property (flags_we |-> flags_out[FLAG_V] == status_flags[FLAG_V])
      else $error("overflow flag changed");
  a_op_latency:
    assert property ($rose(busy) |-> ##[3:7] done) else $error("late done");
  a_one_done:
    assert property (done |=> !done && !busy) else $error("done too long");
  a_result_hold:
    assert property (!wr_en |-> $stable(wr_data) && $stable(wr_addr))
      else $error("result moved");
  a_addr_hold:
    assert property (busy && $past(busy) |-> $stable(rd_addr_b))
      else $error("read address moved");
  a_bad_word:
    assert property (not_multiply |-> !busy ##1 !busy)
      else $error("bad word started");
  c_flag_write: cover property (done && flags_we);
  c_plain_write: cover property (done && !flags_we);
  c_bad_word: cover property (not_multiply);
endmodule
bind mmd_mul_unit mmd_mul_monitor i_mmd_mul_monitor (
  .sys_clk(sys_clk), .srst(srst), .instr_valid(instr_valid),
  .instr_word(instr_word), .status_flags(status_flags), .busy(busy),
  .not_multiply(not_multiply), .rd_addr_a(rd_addr_a),
  .rd_addr_b(rd_addr_b), .rd_addr_c(rd_addr_c), .rd_data_a(rd_data_a),
  .rd_data_b(rd_data_b), .rd_data_c(rd_data_c), .wr_en(wr_en),
  .wr_addr(wr_addr), .wr_data(wr_data), .flags_we(flags_we),
  .flags_out(flags_out), .done(done));
`default_nettype wire

// *** sim/mmd_regfile_model.sv ***
// register file model on the far side of the datapath
`timescale 1ns/1ps
`default_nettype none
module mmd_regfile_model
  import mmd_pkg::*;
(
  // clock
  input  wire logic                 sys_clk,
  // read side
  input  wire logic [REG_IDX_W-1:0] rd_addr_a,
  input  wire logic [REG_IDX_W-1:0] rd_addr_b,
  input  wire logic [REG_IDX_W-1:0] rd_addr_c,
  output logic      [DATA_W-1:0]    rd_data_a,
  output logic      [DATA_W-1:0]    rd_data_b,
  output logic      [DATA_W-1:0]    rd_data_c,
  // write side
  input  wire logic                 wr_en,
  input  wire logic [REG_IDX_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0]    wr_data
);
  logic [DATA_W-1:0] regs [16];
  assign rd_data_a = regs[rd_addr_a];
  assign rd_data_b = regs[rd_addr_b];
  assign rd_data_c = regs[rd_addr_c];
  always @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      regs[wr_addr] <= wr_data;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the multiply datapath
`timescale 1ns/1ps
`default_nettype none
module tb
  import mmd_pkg::*;
;
  logic        sys_clk, srst, instr_valid, busy, not_multiply, wr_en;
  logic        flags_we, done;
  logic [31:0] instr_word, wr_data, rd_data_a, rd_data_b, rd_data_c;
  logic [3:0]  status_flags, flags_out, rd_addr_a, rd_addr_b, rd_addr_c;
  logic [3:0]  wr_addr;
  int          n_mismatch = 0;
  int          n_compared = 0;
  mmd_mul_unit i_mmd_mul_unit (.sys_clk(sys_clk), .srst(srst),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .status_flags(status_flags), .busy(busy), .not_multiply(not_multiply),
    .rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b), .rd_addr_c(rd_addr_c),
    .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .rd_data_c(rd_data_c),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .flags_we(flags_we), .flags_out(flags_out), .done(done));
  mmd_regfile_model i_mmd_regfile_model (.sys_clk(sys_clk),
    .rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b), .rd_addr_c(rd_addr_c),
    .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .rd_data_c(rd_data_c),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int m_of(input logic [31:0] b);
    if (~|b[31:8] || &b[31:8]) return 1;
    if (~|b[31:16] || &b[31:16]) return 2;
    if (~|b[31:24] || &b[31:24]) return 3;
    return 4;
  endfunction
  // edges from issue to done, 10 when none
  task automatic issue(input logic [31:0] w, input logic [3:0] f,
                       output int n, output logic nm);
    n = 0;
    nm = 1'b0;
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    status_flags <= f;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    nm = (not_multiply === 1'b1);
    while (n < 10)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      nm = nm | (not_multiply === 1'b1);
      if (done === 1'b1) break;
    end
  endtask
  task automatic t_op(input logic acc, s, input logic [3:0] rd, rn, rs, rm,
                      input logic [31:0] a, b, c, input logic [3:0] f);
    logic [31:0] e;
    logic        nm;
    int          n;
    i_mmd_regfile_model.regs[rn] = c;
    i_mmd_regfile_model.regs[rs] = b;
    i_mmd_regfile_model.regs[rm] = a;
    e = a * b + (acc ? c : 32'h0);
    issue({CC_AL, 6'h00, acc, s, rd, rn, rs, 4'h9, rm}, f, n, nm);
    chk(n, 2 + m_of(b) + acc);
    chk(wr_data, e);
    chk({28'h0, wr_addr}, {28'h0, rd});
    chk({31'h0, flags_we}, {31'h0, s});
    chk({31'h0, nm}, 32'h0);
    if (s) chk({28'h0, flags_out}, {28'h0, e[31], e == 0, f[1:0]});
  endtask
  task automatic t_cond;
    logic [3:0]  cc [4] = '{CC_EQ, CC_MI, 4'hf, CC_EQ};
    logic [3:0]  ff [4] = '{4'h0, 4'h0, 4'hf, 4'h4};
    logic        nm;
    int          n;
    i_mmd_regfile_model.regs[2] = 32'h3;
    i_mmd_regfile_model.regs[3] = 32'h5;
    for (int i = 0; i < 4; i++)
    begin
      issue({cc[i], 8'h01, 4'h1, 4'h0, 4'h3, 4'h9, 4'h2}, ff[i], n, nm);
      chk(n, (i == 3) ? 3 : 10);
    end
    issue({CC_AL, 8'h00, 4'h1, 4'h0, 4'h3, 4'hb, 4'h2}, 4'h0, n, nm);
    chk(n, 10);
    chk({31'h0, nm}, 32'h1);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************
  // run
  // ****************
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    srst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 32'h0;
    status_flags = 4'h0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    // program counter register never named
    // plain forms keep the accumulate field at zero
    t_op(0, 1, 1, 0, 3, 2, 32'hfffffff6, 32'h14, 32'h5a5a, 4'h3);
    t_op(0, 1, 1, 0, 3, 2, 32'h12345678, 32'hffffff80, 32'h77, 4'h0);
    t_op(0, 0, 4, 0, 3, 2, 32'h00c0ffee, 32'h00001234, 32'h1, 4'h1);
    t_op(0, 1, 4, 0, 6, 2, 32'h87654321, 32'h00abcdef, 32'h1, 4'h2);
    t_op(0, 1, 4, 0, 6, 2, 32'h3, 32'h12345678, 32'h1, 4'h1);
    t_op(1, 1, 5, 5, 5, 6, 32'h1, 32'h80000000, 32'h80000000, 4'h2);
    t_op(1, 0, 7, 8, 9, 4, 32'h5, 32'hffff0001, 32'h64, 4'h0);
    t_cond();
    report_and_stop();
  end
endmodule
`default_nettype wire
